// ==== rtl/dig_top.v ====
// Purpose: Completion interrupt grouping and descriptor list traversal
// Assumes: Done flags arrive as same-clock pulses from the transfer engine
// Notes:   Rules follow, one per line
// Contract
// - Isochronous any-done mask, 32 bits, resets to zero, zero means no OR condition.
// - Periodic any-done mask, 32 bits, resets to zero.
// - Async any-done mask, 32 bits, resets to zero.
// - Isochronous all-done mask, 32 bits, zero means no AND condition.
// - Periodic all-done mask, 32 bits, resets to zero.
// - Async all-done mask, 32 bits, resets to zero.
// - Up to 32 descriptors per list.
// - Schedule runs isochronous, then periodic, then async list.
// - Descriptor completes when its done bit is set.
// - Four interrupt kinds: isochronous, periodic, async, start of frame.
// - Completion latency programmable in whole microframes.
// - Next pointer jumps over unused and skipped descriptors.
// - Next pointer only ever points forward.
// - Traversal ascends, honouring skip flag and last marker.
// - Block is a bus slave only.
// - Isochronous enable gates its completion interrupt.
// - Async enable gates its completion interrupt.
// - Periodic enable gates its completion interrupt.
`timescale 1ns/1ns
`default_nettype none
`include "dig_consts.vh"
// Plain read/write word register, cleared by reset
module dig_word #(
  parameter W = 32
)(
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  input  wire         wr_i,
  input  wire [W-1:0] wdata_i,
  output reg  [W-1:0] q_o
);
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      q_o <= {W{1'b0}};
    else if (wr_i)
      q_o <= wdata_i;
  end
endmodule

// One list's done map, any/all grouping and pending flag
module dig_grp #(
  parameter N_DESC = 32
)(
  input  wire              ref_clk_i,
  input  wire              rst_n_i,
  input  wire [N_DESC-1:0] done_i,
  input  wire [N_DESC-1:0] any_mask_i,
  input  wire [N_DESC-1:0] all_mask_i,
  input  wire [N_DESC-1:0] map_clr_i,
  input  wire              pend_clr_i,
  output reg  [N_DESC-1:0] map_o,
  output reg               pend_o
);
  wire [N_DESC-1:0] map_now;
  wire              any_hit;
  wire              all_hit;
  wire              hit;
  assign map_now = map_o | done_i;
  // OR group fires on a new done of a selected descriptor
  assign any_hit = |(done_i & any_mask_i);
  // AND group fires whenever a member reports done and every selected member is then in the map
  assign all_hit = (|all_mask_i) &&
                   ((map_now & all_mask_i) == all_mask_i) &&
                   (|(done_i & all_mask_i));
  assign hit = any_hit || all_hit;
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      map_o  <= {N_DESC{1'b0}};
      pend_o <= 1'b0;
    end
    else
    begin
      // Writing ones clears map entries; a new done wins
      map_o  <= (map_o & ~map_clr_i) | done_i;
      pend_o <= (pend_o && !pend_clr_i) || hit;
    end
  end
endmodule

module dig_top #(
  parameter N_DESC = 32,
  parameter IDX_W  = 5
)(
  input  wire                   ref_clk_i,
  input  wire                   rst_n_i,
  input  wire [`DIG_ADDR_W-1:0] reg_addr_i,
  input  wire [31:0]            reg_wdata_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  output reg  [31:0]            reg_rdata_o,
  input  wire [N_DESC-1:0]      iso_done_i,
  input  wire [N_DESC-1:0]      per_done_i,
  input  wire [N_DESC-1:0]      asy_done_i,
  input  wire                   sof_i,
  input  wire [N_DESC-1:0]      desc_skip_i,
  input  wire [N_DESC-1:0]      desc_last_i,
  input  wire [IDX_W-1:0]       desc_next_i,
  input  wire                   desc_next_vld_i,
  output reg  [1:0]             list_sel_o,
  output reg  [IDX_W-1:0]       desc_idx_o,
  output reg                    desc_go_o,
  output reg                    irq_o
);
  localparam LAT_CYC = `DIG_UFRAME_NS / `DIG_CLK_NS;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WALK = 2'h1;
  localparam [1:0] S_NEXT = 2'h2;
  // Mask registers, one bit per descriptor
  wire [31:0]          iso_any_reg;
  wire [31:0]          per_any_reg;
  wire [31:0]          asy_any_reg;
  wire [31:0]          iso_all_reg;
  wire [31:0]          per_all_reg;
  wire [31:0]          asy_all_reg;
  reg  [31:0]          enable_reg;
  reg  [3:0]           status_reg;
  reg  [3:0]           irq_mask_reg;
  wire [N_DESC-1:0]    iso_map;
  wire [N_DESC-1:0]    per_map;
  wire [N_DESC-1:0]    asy_map;
  wire                 iso_pend;
  wire                 per_pend;
  wire                 asy_pend;
  reg  [`DIG_LAT_W-1:0] lat_reg;
  reg  [`DIG_LAT_W-1:0] uf_cnt_reg;
  reg  [16:0]          tick_cnt_reg;
  reg                  sched_en_reg;
  reg  [1:0]           state_reg;
  reg  [1:0]           state_next;
  reg  [IDX_W-1:0]     idx_next;
  reg  [1:0]           list_next;
  reg                  go_next;
  wire wr_en = reg_wr_i;
  wire [N_DESC-1:0] iso_map_clr = (wr_en && reg_addr_i == `DIG_OFS_DONE_ISO) ?
                                  reg_wdata_i[N_DESC-1:0] : {N_DESC{1'b0}};
  wire [N_DESC-1:0] per_map_clr = (wr_en && reg_addr_i == `DIG_OFS_DONE_PER) ?
                                  reg_wdata_i[N_DESC-1:0] : {N_DESC{1'b0}};
  wire [N_DESC-1:0] asy_map_clr = (wr_en && reg_addr_i == `DIG_OFS_DONE_ASY) ?
                                  reg_wdata_i[N_DESC-1:0] : {N_DESC{1'b0}};
  wire uf_tick = (tick_cnt_reg == LAT_CYC - 1);
  wire lat_due = uf_tick && (uf_cnt_reg >= lat_reg);
  dig_word #(
    .W(32)
  ) u_iso_any (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_ISO_ANY),
    .wdata_i   (reg_wdata_i),
    .q_o       (iso_any_reg)
  );
  dig_word #(
    .W(32)
  ) u_per_any (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_PER_ANY),
    .wdata_i   (reg_wdata_i),
    .q_o       (per_any_reg)
  );
  dig_word #(
    .W(32)
  ) u_asy_any (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_ASY_ANY),
    .wdata_i   (reg_wdata_i),
    .q_o       (asy_any_reg)
  );
  dig_word #(
    .W(32)
  ) u_iso_all (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_ISO_ALL),
    .wdata_i   (reg_wdata_i),
    .q_o       (iso_all_reg)
  );
  dig_word #(
    .W(32)
  ) u_per_all (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_PER_ALL),
    .wdata_i   (reg_wdata_i),
    .q_o       (per_all_reg)
  );
  dig_word #(
    .W(32)
  ) u_asy_all (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_en && reg_addr_i == `DIG_OFS_ASY_ALL),
    .wdata_i   (reg_wdata_i),
    .q_o       (asy_all_reg)
  );
  // Grouping per list; pending flags clear when the latency timer reports
  dig_grp #(
    .N_DESC(N_DESC)
  ) u_iso_grp (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .done_i     (iso_done_i),
    .any_mask_i (iso_any_reg[N_DESC-1:0]),
    .all_mask_i (iso_all_reg[N_DESC-1:0]),
    .map_clr_i  (iso_map_clr),
    .pend_clr_i (lat_due),
    .map_o      (iso_map),
    .pend_o     (iso_pend)
  );
  dig_grp #(
    .N_DESC(N_DESC)
  ) u_per_grp (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .done_i     (per_done_i),
    .any_mask_i (per_any_reg[N_DESC-1:0]),
    .all_mask_i (per_all_reg[N_DESC-1:0]),
    .map_clr_i  (per_map_clr),
    .pend_clr_i (lat_due),
    .map_o      (per_map),
    .pend_o     (per_pend)
  );
  dig_grp #(
    .N_DESC(N_DESC)
  ) u_asy_grp (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .done_i     (asy_done_i),
    .any_mask_i (asy_any_reg[N_DESC-1:0]),
    .all_mask_i (asy_all_reg[N_DESC-1:0]),
    .map_clr_i  (asy_map_clr),
    .pend_clr_i (lat_due),
    .map_o      (asy_map),
    .pend_o     (asy_pend)
  );
  wire [3:0] ev_set;
  assign ev_set[`DIG_ST_ISO] = lat_due && iso_pend && enable_reg[`DIG_BIT_ISO_E];
  assign ev_set[`DIG_ST_PER] = lat_due && per_pend && enable_reg[`DIG_BIT_PER_E];
  assign ev_set[`DIG_ST_ASY] = lat_due && asy_pend && enable_reg[`DIG_BIT_ASY_E];
  assign ev_set[`DIG_ST_SOF] = sof_i && enable_reg[`DIG_BIT_SOF];
  wire [3:0] st_clr = (wr_en && reg_addr_i == `DIG_OFS_STATUS) ? reg_wdata_i[3:0] : 4'h0;
  // Register writes, status with set winning over clear
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      enable_reg   <= `DIG_RST_WORD;
      irq_mask_reg <= 4'h0;
      status_reg   <= 4'h0;
      lat_reg      <= {`DIG_LAT_W{1'b0}};
      sched_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_en)
      begin
        case (reg_addr_i)
          `DIG_OFS_ENABLE:  enable_reg   <= reg_wdata_i;
          `DIG_OFS_MASK:    irq_mask_reg <= reg_wdata_i[3:0];
          `DIG_OFS_LATENCY: lat_reg      <= reg_wdata_i[`DIG_LAT_W-1:0];
          `DIG_OFS_SCHED:   sched_en_reg <= reg_wdata_i[0];
          default:          sched_en_reg <= sched_en_reg;
        endcase
      end
      status_reg <= (status_reg & ~st_clr) | ev_set;
    end
  end
  // Microframe latency timer and interrupt line
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_reg <= 17'h0_0000;
      uf_cnt_reg   <= {`DIG_LAT_W{1'b0}};
      irq_o        <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= uf_tick ? 17'h0_0000 : tick_cnt_reg + 17'h0_0001;
      if (lat_due)
        uf_cnt_reg <= {`DIG_LAT_W{1'b0}};
      else if (uf_tick)
        uf_cnt_reg <= uf_cnt_reg + {{(`DIG_LAT_W-1){1'b0}}, 1'b1};
      irq_o <= |(status_reg & irq_mask_reg);
    end
  end
  // Read port, data one cycle after the strobe
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= `DIG_RST_WORD;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `DIG_OFS_ENABLE:   reg_rdata_o <= enable_reg;
        `DIG_OFS_ISO_ANY:  reg_rdata_o <= iso_any_reg;
        `DIG_OFS_PER_ANY:  reg_rdata_o <= per_any_reg;
        `DIG_OFS_ASY_ANY:  reg_rdata_o <= asy_any_reg;
        `DIG_OFS_ISO_ALL:  reg_rdata_o <= iso_all_reg;
        `DIG_OFS_PER_ALL:  reg_rdata_o <= per_all_reg;
        `DIG_OFS_ASY_ALL:  reg_rdata_o <= asy_all_reg;
        `DIG_OFS_STATUS:   reg_rdata_o <= {28'h000_0000, status_reg};
        `DIG_OFS_MASK:     reg_rdata_o <= {28'h000_0000, irq_mask_reg};
        `DIG_OFS_DONE_ISO: reg_rdata_o <= iso_map;
        `DIG_OFS_DONE_PER: reg_rdata_o <= per_map;
        `DIG_OFS_DONE_ASY: reg_rdata_o <= asy_map;
        `DIG_OFS_LATENCY:  reg_rdata_o <= {24'h00_0000, lat_reg};
        `DIG_OFS_SCHED:    reg_rdata_o <= {31'h0000_0000, sched_en_reg};
        default:           reg_rdata_o <= `DIG_RST_WORD;
      endcase
    end
    else
      reg_rdata_o <= `DIG_RST_WORD;
  end
  // List walker: one frame runs iso, periodic, async in that order
  always @*
  begin
    state_next = state_reg;
    idx_next   = desc_idx_o;
    list_next  = list_sel_o;
    go_next    = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        if (sched_en_reg && sof_i)
        begin
          state_next = S_WALK;
          list_next  = 2'd0;
          idx_next   = {IDX_W{1'b0}};
        end
      end
      S_WALK:
      begin
        if (!desc_skip_i[desc_idx_o])
          go_next = 1'b1;
        state_next = S_NEXT;
      end
      S_NEXT:
      begin
        state_next = S_WALK;
        if (desc_last_i[desc_idx_o] || desc_idx_o == N_DESC - 1)
        begin
          idx_next = {IDX_W{1'b0}};
          if (list_sel_o == 2'd2)
            state_next = S_IDLE;
          else
            list_next = list_sel_o + 2'd1;
        end
        else if (!desc_skip_i[desc_idx_o] && desc_next_vld_i && desc_next_i > desc_idx_o)
          idx_next = desc_next_i;
        else
          idx_next = desc_idx_o + {{(IDX_W-1){1'b0}}, 1'b1};
      end
      default: state_next = S_IDLE;
    endcase
  end
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg  <= S_IDLE;
      desc_idx_o <= {IDX_W{1'b0}};
      list_sel_o <= 2'd0;
      desc_go_o  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      desc_idx_o <= idx_next;
      list_sel_o <= list_next;
      desc_go_o  <= go_next;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dig_consts.vh ====
// Purpose: Constants for the descriptor done interrupt grouping block
// Assumes: 12-bit register byte addresses, 32-bit data
// Notes:   Offsets are byte addresses
`ifndef DIG_CONSTS_VH
`define DIG_CONSTS_VH
`define DIG_ADDR_W          12
`define DIG_OFS_ENABLE      12'h0314
`define DIG_OFS_ISO_ANY     12'h0318
`define DIG_OFS_PER_ANY     12'h031C
`define DIG_OFS_ASY_ANY     12'h0320
`define DIG_OFS_ISO_ALL     12'h0324
`define DIG_OFS_PER_ALL     12'h0328
`define DIG_OFS_ASY_ALL     12'h032C
`define DIG_OFS_STATUS      12'h0330
`define DIG_OFS_MASK        12'h0334
`define DIG_OFS_DONE_ISO    12'h0338
`define DIG_OFS_DONE_PER    12'h033C
`define DIG_OFS_DONE_ASY    12'h0340
`define DIG_OFS_LATENCY     12'h0344
`define DIG_OFS_SCHED       12'h0348
`define DIG_RST_WORD        32'h0000_0000
`define DIG_BIT_SOF         1
`define DIG_BIT_PER_E       7
`define DIG_BIT_ASY_E       8
`define DIG_BIT_ISO_E       9
`define DIG_ST_ISO          0
`define DIG_ST_PER          1
`define DIG_ST_ASY          2
`define DIG_ST_SOF          3
`define DIG_UFRAME_NS       125000
`define DIG_CLK_NS          10
`define DIG_LAT_W           8
`endif

// ==== dv/dig_top_monitor.sv ====
// Purpose: Port-level checks of the completion grouping block
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to dig_top by bind
`timescale 1ns/1ns
`default_nettype none
`include "dig_consts.vh"
module dig_top_monitor #(
  parameter N_DESC = 32,
  parameter IDX_W  = 5
)(
  input wire logic                   ref_clk_i,
  input wire logic                   rst_n_i,
  input wire logic [`DIG_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]            reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [31:0]            reg_rdata_o,
  input wire logic [N_DESC-1:0]      desc_skip_i,
  input wire logic [N_DESC-1:0]      desc_last_i,
  input wire logic [1:0]             list_sel_o,
  input wire logic [IDX_W-1:0]       desc_idx_o,
  input wire logic                   desc_go_o,
  input wire logic                   irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Aligned write to one of the six grouping masks
  wire logic mask_wr = reg_wr_i && reg_addr_i[1:0] == 2'h0 &&
    reg_addr_i >= `DIG_OFS_ISO_ANY && reg_addr_i <= `DIG_OFS_ASY_ALL;
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_mask_read_back: assert property (mask_wr ##2 (reg_rd_i && reg_addr_i == $past(reg_addr_i, 2))
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("mask read back differs");
  a_go_not_skipped: assert property (desc_go_o |-> !desc_skip_i[desc_idx_o])
    else $error("skipped descriptor executed");
  a_go_single_pulse: assert property (desc_go_o |=> !desc_go_o)
    else $error("execute pulse longer than one cycle");
  a_idx_ascends: assert property ($changed(desc_idx_o) && $stable(list_sel_o) && desc_idx_o != 0
    |-> desc_idx_o > $past(desc_idx_o)) else $error("descriptor index moved backward");
  a_list_order: assert property ($changed(list_sel_o) |-> list_sel_o == 2'h0 ||
    (list_sel_o != 2'h3 && list_sel_o == $past(list_sel_o) + 2'h1)) else $error("list order");
  a_last_ends_list: assert property (desc_go_o && desc_last_i[desc_idx_o] && list_sel_o == 2'h0
    |-> ##[1:4] list_sel_o == 2'h1) else $error("last marker did not end the list");
  a_irq_drop_cause: assert property ($fell(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("interrupt dropped without a register write");
endmodule
bind dig_top dig_top_monitor #(.N_DESC(N_DESC), .IDX_W(IDX_W)) u_mon (.ref_clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .desc_skip_i, .desc_last_i,
  .list_sel_o, .desc_idx_o, .desc_go_o, .irq_o);
`default_nettype wire

// ==== dv/dig_top_tb.sv ====
// Purpose: Self-checking bench of the completion grouping block
// Assumes: Microframe tick every 12500 cycles
// Notes:   Skip, last and next pointer inputs are fixed
`timescale 1ns/1ns
`default_nettype none
`include "dig_consts.vh"
module dig_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sof = 1'b0;
  logic [31:0] iso_d = 32'h0;
  logic [31:0] per_d = 32'h0;
  logic [31:0] asy_d = 32'h0;
  logic [31:0] rdata;
  logic [1:0]  lsel;
  logic [4:0]  idx;
  logic        go;
  logic        irq;
  int          n_fail = 0;
  int          checks = 0;
  int          go_cnt [3] = '{0, 0, 0};
  always #5 clk = ~clk;
  always @(posedge clk) if (go === 1'b1 && lsel < 2'h3) go_cnt[lsel] <= go_cnt[lsel] + 1;
  // Skip 1 and 2, last at 4, next pointer 4: expect execution at 0 and 4 only
  dig_top DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .iso_done_i(iso_d), .per_done_i(per_d),
    .asy_done_i(asy_d), .sof_i(sof), .desc_skip_i(32'h0000_0006), .desc_last_i(32'h0000_0010),
    .desc_next_i(5'h4), .desc_next_vld_i(1'b1), .list_sel_o(lsel), .desc_idx_o(idx),
    .desc_go_o(go), .irq_o(irq));
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write leaves one idle edge so the strobe is never re-raised in the same step
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    cmp(rdata, e);
  endtask
  task automatic pulse(input logic [31:0] i, input logic [31:0] p, input logic [31:0] a);
    iso_d <= i;
    per_d <= p;
    asy_d <= a;
    @(posedge clk);
    iso_d <= 32'h0;
    per_d <= 32'h0;
    asy_d <= 32'h0;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 13000 && irq !== 1'b1; n++) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) print_verdict();
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) chk(`DIG_OFS_ISO_ANY + 12'(4 * i), 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(`DIG_OFS_ISO_ANY + 12'(4 * i), 32'hA5C3_0001 << i);
      chk(`DIG_OFS_ISO_ANY + 12'(4 * i), 32'hA5C3_0001 << i);
    end
    for (int i = 0; i < 6; i++)
    begin
      chk(`DIG_OFS_ISO_ANY + 12'(4 * i), 32'hA5C3_0001 << i);
      wr_reg(`DIG_OFS_ISO_ANY + 12'(4 * i), 32'h0);
    end
    wr_reg(12'h300, 32'hFFFF_FFFF);
    chk(12'h300, 32'h0);
    wr_reg(`DIG_OFS_ENABLE, 32'h0000_0302);
    wr_reg(`DIG_OFS_MASK, 32'h0000_000F);
    wr_reg(`DIG_OFS_ISO_ANY, 32'h0000_0008);
    wr_reg(`DIG_OFS_PER_ANY, 32'h0000_0001);
    wr_reg(`DIG_OFS_ASY_ALL, 32'h8000_0001);
    pulse(32'h0000_0020, 32'h0000_0001, 32'h0000_0001);
    repeat (12600) @(posedge clk);
    chk(`DIG_OFS_STATUS, 32'h0);
    pulse(32'h0000_0008, 32'h0, 32'h8000_0000);
    wait_irq();
    chk(`DIG_OFS_STATUS, 32'h0000_0005);
    wr_reg(`DIG_OFS_STATUS, 32'h0000_0005);
    chk(`DIG_OFS_STATUS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr_reg(`DIG_OFS_SCHED, 32'h0000_0001);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    wait_irq();
    for (int n = 0; n < 300 && go_cnt[2] < 2; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 3; i++) cmp(go_cnt[i], 32'h2);
    wr_reg(`DIG_OFS_MASK, 32'h0);
    @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    chk(`DIG_OFS_STATUS, 32'h0000_0008);
    print_verdict();
  end
endmodule
`default_nettype wire
